// ===== hw/irx_pkg.sv
// Purpose: Constants and types of the isochronous receive context status block
// Assumes: Byte addresses on a 12-bit Wishbone window, 32-bit data
// Notes:   Event codes follow the open host controller numbering
`default_nettype none
package irx_pkg;
   localparam int          IRX_NCTX        = 4;
   localparam int          IRX_AW          = 12;
   // Register offsets
   localparam logic [11:0] IRX_CTL_SET_OFS = 12'h400;
   localparam logic [11:0] IRX_CTL_CLR_OFS = 12'h404;
   localparam logic [11:0] IRX_PTR_OFS     = 12'h40c;
   localparam logic [11:0] IRX_CTX_STRIDE  = 12'h020;
   localparam logic [11:0] IRX_STAT_OFS    = 12'h480;
   localparam logic [11:0] IRX_MASK_OFS    = 12'h484;
   // Control field positions
   localparam int          IRX_B_FILL      = 31;
   localparam int          IRX_B_RUN       = 15;
   localparam int          IRX_B_WAKE      = 12;
   localparam int          IRX_B_DEAD      = 11;
   localparam int          IRX_B_ACTIVE    = 10;
   localparam int          IRX_B_SPD       = 5;
   localparam int          IRX_B_CODE      = 0;
   // Speed codes
   localparam logic [2:0]  IRX_SPD_100     = 3'h0;
   localparam logic [2:0]  IRX_SPD_200     = 3'h1;
   localparam logic [2:0]  IRX_SPD_400     = 3'h2;
   // Completion codes
   localparam logic [4:0]  IRX_DONE_OK     = 5'h11;
   localparam logic [4:0]  IRX_PAYLOAD     = 5'h1d;
   localparam logic [4:0]  IRX_OVERSIZE    = 5'h02;
   localparam logic [4:0]  IRX_FIFO_OVF    = 5'h05;
   localparam logic [4:0]  IRX_DESCR_RD    = 5'h06;
   localparam logic [4:0]  IRX_DATA_WR     = 5'h08;
   localparam logic [4:0]  IRX_UNKNOWN     = 5'h0e;
   // Values after reset
   localparam logic [31:0] IRX_PTR_RST     = 32'h0000_0000;
   localparam logic [2:0]  IRX_SPD_RST     = 3'h0;
   localparam logic [4:0]  IRX_CODE_RST    = 5'h00;
   localparam logic [7:0]  IRX_MASK_RST    = 8'h00;
   localparam logic [7:0]  IRX_STAT_RST    = 8'h00;

   typedef struct packed {
      logic        fill;
      logic        run;
      logic        wake;
      logic        dead;
      logic        active;
      logic        start;
      logic        backout;
      logic        done_ev;
      logic        fatal_ev;
      logic [2:0]  spd;
      logic [4:0]  code;
      logic [31:0] ptr;
   } irx_ctx_t;
endpackage
`default_nettype wire

// ===== hw/irx_bus_if.sv
// Purpose: Decoded register request between bus slave and core
// Assumes: req is a one-cycle pulse per bus cycle
// Notes:   rdat is combinational from the core
`default_nettype none
interface irx_bus_if;
   logic        req;
   logic        we;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   modport slave (output req, output we, output adr, output sel, output wdat, input rdat);
   modport core  (input req, input we, input adr, input sel, input wdat, output rdat);
endinterface
`default_nettype wire

// ===== hw/irx_wb_slave.sv
// Purpose: Classic Wishbone slave, one wait state
// Assumes: Master holds the request until it samples ack
// Notes:   Read data and ack come from flops
`default_nettype none
module irx_wb_slave
   import irx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Wishbone
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // Core side
   irx_bus_if.slave         bus
);
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } irx_wb_t;

   irx_wb_t q;
   irx_wb_t next_q;

   assign bus.req  = wb_cyc_i & wb_stb_i & ~q.ack;
   assign bus.we   = wb_we_i;
   assign bus.adr  = wb_adr_i;
   assign bus.sel  = wb_sel_i;
   assign bus.wdat = wb_dat_i;
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;

   always_comb begin
      next_q     = q;
      next_q.ack = bus.req;
      if (bus.req && !wb_we_i) begin
         next_q.dat = bus.rdat;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule // irx_wb_slave
`default_nettype wire

// ===== hw/irx_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Events are one-cycle pulses
// Notes:   Read clears status; a new event in that cycle survives
`default_nettype none
module irx_irq
   import irx_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Events
   input  wire logic [7:0] events,
   // Software access
   input  wire logic       rd_stat,
   input  wire logic       wr_mask,
   input  wire logic [7:0] wdat,
   input  wire logic [7:0] wmask,
   // State
   output var  logic [7:0] status,
   output var  logic [7:0] mask,
   output var  logic       irq
);
   typedef struct packed {
      logic [7:0] stat;
      logic [7:0] mask;
      logic       irq;
   } irx_irq_t;

   irx_irq_t q;
   irx_irq_t next_q;

   assign status = q.stat;
   assign mask   = q.mask;
   assign irq    = q.irq;

   always_comb begin
      next_q = q;
      if (rd_stat) begin
         next_q.stat = '0;
      end
      next_q.stat = next_q.stat | events;
      if (wr_mask) begin
         next_q.mask = (q.mask & ~wmask) | (wdat & wmask);
      end
      next_q.irq = |(next_q.stat & next_q.mask);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{stat: IRX_STAT_RST, mask: IRX_MASK_RST, irq: 1'b0};
      end else begin
         q <= next_q;
      end
   end
endmodule // irx_irq
`default_nettype wire

// ===== hw/irx_top.sv
// Purpose: Status and control of four isochronous receive contexts
// Assumes: Fetch engine signals are on clk_sys; Wishbone classic slave
// Notes:   Set and clear registers share one control word per context
//
// How it works
// - Each descriptor fetch clears resume_request unless software sets it in the same cycle.
// - A fatal error while context_enable is set sets fatal_halt_flag.
// - fatal_halt_flag clears only when software clears context_enable.
// - processing_flag is one while the context processes descriptors.
// - Control bits 14..13 and 9..8 read as zero.
// - rx_speed_code in bits 7..5: 000, 001, 010 for 100, 200, 400 Mbit/s.
// - In fill_mode completion_code is ok, descriptor read, data write or unknown.
// - In fill_mode packets with length, CRC or overrun errors are backed out.
// - Packet-per-buffer mode reports seven completion codes.
// - Setting context_enable fetches the first block at the command pointer.
// - Four contexts, registers 32 bytes apart.
// - fill_mode packs packets back to back; otherwise one packet per buffer.
//
// The Wishbone interface to the registers is this design's own decision.
`default_nettype none
module irx_top
   import irx_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   // Wishbone
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [11:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output var  logic [31:0]          wb_dat_o,
   output var  logic                 wb_ack_o,
   // Descriptor fetch engine reports
   input  wire logic [3:0]           fe_fetch,
   input  wire logic [3:0]           fe_fatal,
   input  wire logic [3:0]           fe_idle,
   input  wire logic [3:0]           fe_done,
   input  wire logic [2:0]           fe_spd,
   input  wire logic [4:0]           fe_code,
   input  wire logic [3:0]           fe_ptr_load,
   input  wire logic [31:0]          fe_ptr,
   // Descriptor fetch engine controls
   output var  logic [3:0]           fetch_start,
   output var  logic [3:0][31:0]     fetch_addr,
   output var  logic [3:0]           ctx_run,
   output var  logic [3:0]           ctx_fill,
   output var  logic [3:0]           ctx_active,
   output var  logic [3:0]           rx_backout,
   // Interrupt
   output var  logic                 irq
);
   irx_bus_if bus ();

   logic [31:0]          wmask;
   logic [31:0]          wbits;
   logic [3:0][31:0]     ctl_word;
   logic [3:0]           done_ev;
   logic [3:0]           fatal_ev;
   logic                 rd_stat;
   logic                 wr_mask;
   logic [7:0]           irq_status;
   logic [7:0]           irq_mask;

   irx_wb_slave u_wb (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .bus      (bus)
   );

   // Byte lanes to bit mask
   assign wmask = {{8{bus.sel[3]}}, {8{bus.sel[2]}}, {8{bus.sel[1]}}, {8{bus.sel[0]}}};
   assign wbits = bus.wdat & wmask;

   assign rd_stat = bus.req & ~bus.we & (bus.adr == IRX_STAT_OFS);
   assign wr_mask = bus.req & bus.we & (bus.adr == IRX_MASK_OFS);

   irx_irq u_irq (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .events  ({fatal_ev, done_ev}),
      .rd_stat (rd_stat),
      .wr_mask (wr_mask),
      .wdat    (bus.wdat[7:0]),
      .wmask   (wmask[7:0]),
      .status  (irq_status),
      .mask    (irq_mask),
      .irq     (irq)
   );

   // Per-context state
   for (genvar n = 0; n < IRX_NCTX; n++) begin : g_ctx
      localparam logic [11:0] BASE = 12'(n) * IRX_CTX_STRIDE;

      irx_ctx_t q;
      irx_ctx_t next_q;
      logic     wr_set;
      logic     wr_clr;
      logic     sw_run_set;
      logic     sw_run_clr;
      logic     sw_wake;
      logic     run_rise;
      logic     resume;
      logic     bad_pkt;
      logic     code_ok;
      logic [31:0] word;

      assign wr_set = bus.req & bus.we & (bus.adr == 12'(IRX_CTL_SET_OFS + BASE));
      assign wr_clr = bus.req & bus.we & (bus.adr == 12'(IRX_CTL_CLR_OFS + BASE));

      assign sw_run_set = wr_set & wbits[IRX_B_RUN];
      assign sw_run_clr = wr_clr & wbits[IRX_B_RUN];
      assign sw_wake    = wr_set & wbits[IRX_B_WAKE];

      // Errors a filled buffer cannot keep
      assign bad_pkt = (fe_code == IRX_PAYLOAD) | (fe_code == IRX_OVERSIZE) | (fe_code == IRX_FIFO_OVF);

      always_comb begin
         code_ok = 1'b0;
         case (fe_code)
            IRX_DONE_OK,
            IRX_DESCR_RD,
            IRX_DATA_WR,
            IRX_UNKNOWN:  code_ok = 1'b1;
            IRX_PAYLOAD,
            IRX_OVERSIZE,
            IRX_FIFO_OVF: code_ok = ~q.fill;
            default:      code_ok = 1'b0;
         endcase
      end

      always_comb begin
         next_q          = q;
         next_q.start    = 1'b0;
         next_q.backout  = 1'b0;
         next_q.done_ev  = 1'b0;
         next_q.fatal_ev = 1'b0;
         run_rise        = 1'b0;
         resume          = 1'b0;

         // fill_mode and context_enable via set and clear words
         if (wr_set && wbits[IRX_B_FILL]) begin
            next_q.fill = 1'b1;
         end
         if (wr_clr && wbits[IRX_B_FILL]) begin
            next_q.fill = 1'b0;
         end
         if (sw_run_set) begin
            next_q.run = 1'b1;
            run_rise   = ~q.run;
         end
         if (sw_run_clr) begin
            next_q.run = 1'b0;
         end

         // Resume request: fetch clears, software set wins
         if (fe_fetch[n]) begin
            next_q.wake = 1'b0;
         end
         if (sw_wake) begin
            next_q.wake = 1'b1;
         end

         // Fatal flag held until context_enable clears
         if (!next_q.run) begin
            next_q.dead = 1'b0;
         end
         if (fe_fatal[n] && q.run) begin
            next_q.dead     = 1'b1;
            next_q.fatal_ev = ~q.dead;
         end

         // Start or resume descriptor processing
         resume = sw_wake & q.run & ~q.active & ~q.dead;
         if ((run_rise || resume) && !next_q.dead) begin
            next_q.start  = 1'b1;
            next_q.active = 1'b1;
         end
         if (!next_q.run || next_q.dead || (fe_idle[n] && !next_q.start)) begin
            next_q.active = 1'b0;
         end

         // Pointer advanced by the fetch engine
         if (fe_ptr_load[n]) begin
            next_q.ptr = fe_ptr;
         end

         // Completion of a descriptor
         if (fe_done[n] && q.run) begin
            if (q.fill && bad_pkt) begin
               next_q.backout = 1'b1;
            end else begin
               next_q.spd     = fe_spd;
               next_q.code    = code_ok ? fe_code : IRX_UNKNOWN;
               next_q.done_ev = 1'b1;
            end
         end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            q <= '{fill: 1'b0, run: 1'b0, wake: 1'b0, dead: 1'b0, active: 1'b0,
                   start: 1'b0, backout: 1'b0, done_ev: 1'b0, fatal_ev: 1'b0,
                   spd: IRX_SPD_RST, code: IRX_CODE_RST, ptr: IRX_PTR_RST};
         end else begin
            q <= next_q;
         end
      end

      // Control word as software sees it, reserved bits zero
      always_comb begin
         word                = '0;
         word[IRX_B_FILL]    = q.fill;
         word[IRX_B_RUN]     = q.run;
         word[IRX_B_WAKE]    = q.wake;
         word[IRX_B_DEAD]    = q.dead;
         word[IRX_B_ACTIVE]  = q.active;
         word[IRX_B_SPD+:3]  = q.spd;
         word[IRX_B_CODE+:5] = q.code;
      end

      assign ctl_word[n]    = word;

      assign fetch_start[n] = q.start;
      assign fetch_addr[n]  = q.ptr;
      assign ctx_run[n]     = q.run;
      assign ctx_fill[n]    = q.fill;
      assign ctx_active[n]  = q.active;
      assign rx_backout[n]  = q.backout;
      assign done_ev[n]     = q.done_ev;
      assign fatal_ev[n]    = q.fatal_ev;
   end

   // Read multiplexer, unmapped reads return zero
   always_comb begin
      bus.rdat = '0;
      if (bus.adr == IRX_STAT_OFS) begin
         bus.rdat = {24'h00_0000, irq_status};
      end
      if (bus.adr == IRX_MASK_OFS) begin
         bus.rdat = {24'h00_0000, irq_mask};
      end
      for (int i = 0; i < IRX_NCTX; i++) begin
         if (bus.adr == 12'(IRX_CTL_SET_OFS + 12'(i) * IRX_CTX_STRIDE) ||
             bus.adr == 12'(IRX_CTL_CLR_OFS + 12'(i) * IRX_CTX_STRIDE)) begin
            bus.rdat = ctl_word[i];
         end
         if (bus.adr == 12'(IRX_PTR_OFS + 12'(i) * IRX_CTX_STRIDE)) begin
            bus.rdat = fetch_addr[i];
         end
      end
   end
endmodule // irx_top
`default_nettype wire

// ===== bench/irx_top_sva.sv
// Purpose: Port assertions for irx_top
// Assumes: One clock, async active-low reset
// Notes:   Context 0 stands for the others; backout cause checks use context 3, a_run_soft and a_ppb_keeps all four
`default_nettype none
module irx_top_sva
   import irx_pkg::*;
(
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       arst_n,
   // Bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic       wb_ack_o,
   // Engine
   input wire logic [3:0] fe_idle,
   input wire logic [3:0] fe_done,
   input wire logic [4:0] fe_code,
   input wire logic [3:0] fetch_start,
   input wire logic [3:0] ctx_run,
   input wire logic [3:0] ctx_fill,
   input wire logic [3:0] ctx_active,
   input wire logic [3:0] rx_backout,
   input wire logic       irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic req;
   logic wr;
   logic bad;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr  = req && wb_we_i;
   assign bad = fe_code inside {IRX_PAYLOAD, IRX_OVERSIZE, IRX_FIFO_OVF};
   a_ack_answer: assert property (req |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_start_run: assert property (fetch_start[0] |-> ctx_run[0] && ctx_active[0])
      else $error("start without run");
   a_start_pulse: assert property (fetch_start[0] |=> !fetch_start[0])
      else $error("start too long");
   a_idle_stops: assert property (fe_idle[0] && !wr |=> !ctx_active[0])
      else $error("active after idle");
   a_active_cause: assert property ($rose(ctx_active[0]) |-> $past(wr))
      else $error("active without write");
   a_run_soft: assert property ($changed(ctx_run) |-> $past(wr))
      else $error("run changed by device");
   a_backout_cause: assert property (rx_backout[3] |-> $past(fe_done[3] && ctx_fill[3] && ctx_run[3] && bad))
      else $error("backout without cause");
   a_backout_made: assert property (fe_done[3] && ctx_fill[3] && ctx_run[3] && bad && !wr |=> rx_backout[3])
      else $error("backout missing");
   a_ppb_keeps: assert property ((rx_backout & ~$past(ctx_fill)) == 4'h0)
      else $error("backout in packet mode");
   c_start: cover property (fetch_start[0]);
   c_backout: cover property (rx_backout[3]);
   c_irq: cover property ($rose(irq));
endmodule // irx_top_sva
bind irx_top irx_top_sva i_sva (.*);
`default_nettype wire

// ===== bench/irx_fe_model.sv
// Purpose: Descriptor fetch engine model
// Assumes: Fetch answer after one or three cycles
// Notes:   slow changes only while no fetch is pending
`default_nettype none
module irx_fe_model (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       arst_n,
   // Control
   input wire logic       slow,
   input wire logic [3:0] fetch_start,
   // Report
   output var logic [3:0] fe_fetch
);
   logic [3:0] d1, d2, d3;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         d1 <= 4'h0;
         d2 <= 4'h0;
         d3 <= 4'h0;
      end else begin
         d1 <= fetch_start;
         d2 <= d1;
         d3 <= d2;
      end
   end
   assign fe_fetch = slow ? d3 : d1;
endmodule // irx_fe_model
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: Register level test of irx_top
// Assumes: Wishbone classic master, fetch engine model
// Notes:   Contexts 1 and 3 run packet and fill modes
`default_nettype none
module testbench
   import irx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, slow;
   logic [11:0]      wb_adr_i;
   logic [3:0]       wb_sel_i, fe_fetch, fe_fatal, fe_idle, fe_done, fe_ptr_load;
   logic [3:0]       fetch_start, ctx_run, ctx_fill, ctx_active, rx_backout;
   logic [31:0]      wb_dat_i, wb_dat_o, fe_ptr, q, fexp;
   logic [2:0]       fe_spd;
   logic [4:0]       fe_code, cd;
   logic [3:0][31:0] fetch_addr;
   logic [4:0]       codes [8] = '{IRX_DONE_OK, IRX_PAYLOAD, IRX_OVERSIZE, IRX_FIFO_OVF,
                                   IRX_DESCR_RD, IRX_DATA_WR, IRX_UNKNOWN, 5'h1f};
   int               bad_count, comparisons;
   irx_top      i_dut (.*);
   irx_fe_model i_fe (.*);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (i < 20 && wb_ack_o !== 1'b1);
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(exp, q);
   endtask
   task automatic ev(input logic [3:0] ld, ft, id, dn, input logic [31:0] p, input logic [7:0] sc);
      @(posedge clk_sys);
      {fe_ptr_load, fe_fatal, fe_idle, fe_done} <= {ld, ft, id, dn};
      {fe_spd, fe_code} <= sc;
      fe_ptr <= p;
      @(posedge clk_sys);
      {fe_ptr_load, fe_fatal, fe_idle, fe_done} <= 16'h0;
   endtask
   task automatic wait_fetch(input int n);
      int i;
      i = 0;
      while (i < 20 && fe_fetch[n] !== 1'b1) begin
         @(negedge clk_sys);
         i++;
      end
      if (fe_fetch[n] !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
   endtask
   function automatic logic [11:0] ca(input logic [11:0] b, input int n);
      return b + IRX_CTX_STRIDE * 12'(n);
   endfunction
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {fe_fatal, fe_idle, fe_done, fe_ptr_load, fe_ptr, fe_spd, fe_code, slow} = '0;
      bad_count = 0;
      comparisons = 0;
      arst_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Pointers, start of each context
      for (int n = 0; n < 4; n++) begin
         rdc(ca(IRX_PTR_OFS, n), IRX_PTR_RST);
         ev(4'h1 << n, 4'h0, 4'h0, 4'h0, 32'h1000 + 32'(n * 256), 8'h00);
         wr(ca(IRX_PTR_OFS, n), 32'hffff_ffff);
         rdc(ca(IRX_PTR_OFS, n), 32'h1000 + 32'(n * 256));
         slow <= n[0];
         wr(ca(IRX_CTL_SET_OFS, n), n == 3 ? 32'hffff_ffff : 32'h0000_8000);
         wait_fetch(n);
         chk(32'h1000 + 32'(n * 256), fetch_addr[n]);
         rdc(ca(IRX_CTL_CLR_OFS, n), n == 3 ? 32'h8000_8400 : 32'h0000_8400);
      end
      // Idle then resume
      ev(4'h0, 4'h0, 4'h1, 4'h0, 32'h0, 8'h00);
      rdc(IRX_CTL_SET_OFS, 32'h0000_8000);
      wr(IRX_CTL_SET_OFS, 32'h0000_1000);
      wait_fetch(0);
      rdc(IRX_CTL_SET_OFS, 32'h0000_8400);
      // Fatal halt and its interrupt
      ev(4'h0, 4'h1, 4'h0, 4'h0, 32'h0, 8'h00);
      rdc(IRX_CTL_SET_OFS, 32'h0000_8800);
      chk(32'h0, {31'h0, irq});
      wr(IRX_MASK_OFS, 32'h0000_0010);
      @(negedge clk_sys);
      chk(32'h1, {31'h0, irq});
      rdc(IRX_STAT_OFS, 32'h0000_0010);
      @(negedge clk_sys);
      chk(32'h0, {31'h0, irq});
      wr(IRX_CTL_SET_OFS, 32'h0000_1000);
      rdc(IRX_CTL_SET_OFS, 32'h0000_9800);
      wr(IRX_CTL_CLR_OFS, 32'h0000_9000);
      rdc(IRX_CTL_SET_OFS, 32'h0000_1000);
      ev(4'h0, 4'h1, 4'h0, 4'h0, 32'h0, 8'h00);
      rdc(IRX_CTL_SET_OFS, 32'h0000_1000);
      // Completion codes, both modes
      fexp = 32'h8000_8400;
      for (int i = 0; i < 8; i++) begin
         cd = (codes[i] == 5'h1f) ? IRX_UNKNOWN : codes[i];
         ev(4'h0, 4'h0, 4'h0, 4'ha, 32'h0, {3'(i % 3), codes[i]});
         rdc(ca(IRX_CTL_SET_OFS, 1), 32'h0000_8400 | {24'h0, 3'(i % 3), cd});
         if (!(codes[i] inside {IRX_PAYLOAD, IRX_OVERSIZE, IRX_FIFO_OVF}))
            fexp = 32'h8000_8400 | {24'h0, 3'(i % 3), cd};
         rdc(ca(IRX_CTL_SET_OFS, 3), fexp);
      end
      wr(IRX_MASK_OFS, 32'h0000_000a);
      @(negedge clk_sys);
      chk(32'h1, {31'h0, irq});
      rdc(IRX_STAT_OFS, 32'h0000_000a);
      rdc(12'h7f0, 32'h0);
      // Stop the fill context and clear fill_mode in one write; later completions are ignored
      wr(ca(IRX_CTL_CLR_OFS, 3), 32'h8000_8000);
      rdc(ca(IRX_CTL_SET_OFS, 3), fexp & 32'h0000_00ff);
      ev(4'h0, 4'h0, 4'h0, 4'h8, 32'h0, {IRX_SPD_400, IRX_DONE_OK});
      rdc(ca(IRX_CTL_CLR_OFS, 3), fexp & 32'h0000_00ff);
      rdc(IRX_STAT_OFS, 32'h0000_0000);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
